// ===== rtl/cspp_regs.sv
`timescale 1ns/10ps
// Summary of operation
// RL1 - field 6:4 of dll control supplies the c-state condition for dll off
// RL2 - code 000 (reset) never allows master dll power-down in c0..c4
// RL3 - code 110 allows dll power-down in c3 or c4 only; others reserved
// RL4 - config bit 4 picks legacy (0) or enhanced (1) power management
// RL5 - config bit 3: snoop asks hub for c2 (0) or c0 (1)
// RL6 - software should keep the snoop behaviour bit at 0
// RL7 - mode 00 (reset) permits all enhanced transitions; 11 reserved
// RL8 - mode 01 blocks c2 to c3, never deeper than c2
// RL9 - mode 10 blocks c3 to c4, never deeper than c3
// RL10 - mode field ignored while enhanced enable bit is 0
// RL11 - software should program the mode field with 00
// RL12 - ro reserved bits read zero; rw reserved bits store, no effect
module cspp_regs
   import cspp_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [11:0] reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic [2:0]  cpu_cstate,
   input  wire logic        snoop_detect,
   output logic      [31:0] reg_rdata,
   output logic             mdll_pd_allow,
   output logic             enh_pm_mode,
   output logic             snoop_req_valid,
   output logic      [2:0]  snoop_req_cstate,
   output logic             c3_entry_allow,
   output logic             c4_entry_allow
);

   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      logic [15:0] mdll_pdc;
      logic [31:0] pm_cfg;
      logic [31:0] rdata;
      logic        pd_allow;
      logic        enh;
      logic        snp_vld;
      logic [2:0]  snp_cst;
      logic        c3_ok;
      logic        c4_ok;
   } cspp_state_type;

   cspp_state_type s_q;
   cspp_state_type s_d;

   logic [2:0] dep;
   logic [1:0] mode;
   logic       deep;

   assign dep  = s_q.mdll_pdc[MDLL_DEP_MSB:MDLL_DEP_LSB];
   assign mode = s_q.pm_cfg[PM_MODE_MSB:PM_MODE_LSB];
   assign deep = (cpu_cstate == CST_C3) || (cpu_cstate == CST_C4);

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      s_d = s_q;
      // writes keep only storable bits; ro reserved bits stay zero
      if (reg_wr && reg_addr == MDLL_PDC_OFFSET) begin
         s_d.mdll_pdc = 16'h0000;
         s_d.mdll_pdc[MDLL_DEP_MSB:MDLL_DEP_LSB] =
            reg_wdata[MDLL_DEP_MSB:MDLL_DEP_LSB];              // RL1
         s_d.mdll_pdc[MDLL_RSVD_RW_MSB:MDLL_RSVD_RW_LSB] =
            reg_wdata[MDLL_RSVD_RW_MSB:MDLL_RSVD_RW_LSB];      // RL12
         s_d.mdll_pdc[3:0] = reg_wdata[3:0];                   // RL12
      end
      if (reg_wr && reg_addr == PM_CFG_OFFSET) begin
         s_d.pm_cfg = 32'h00000000;
         s_d.pm_cfg[PM_RSVD_HI_MSB:PM_RSVD_HI_LSB] =
            reg_wdata[PM_RSVD_HI_MSB:PM_RSVD_HI_LSB];          // RL12
         s_d.pm_cfg[PM_ENH_EN_BIT] = reg_wdata[PM_ENH_EN_BIT];
         s_d.pm_cfg[PM_SNOOP_BIT]  = reg_wdata[PM_SNOOP_BIT];
         s_d.pm_cfg[PM_RSVD2_BIT]  = reg_wdata[PM_RSVD2_BIT];  // RL12
         s_d.pm_cfg[PM_MODE_MSB:PM_MODE_LSB] =
            reg_wdata[PM_MODE_MSB:PM_MODE_LSB];
      end
      // read data registered; unmapped offsets read zero
      s_d.rdata = 32'h00000000;
      if (reg_rd) begin
         case (reg_addr)
            MDLL_PDC_OFFSET: s_d.rdata = {16'h0000, s_q.mdll_pdc};
            PM_CFG_OFFSET:   s_d.rdata = s_q.pm_cfg;
            default:         s_d.rdata = 32'h00000000;
         endcase
      end
      // reserved codes treated as never, the safe choice for the dll
      s_d.pd_allow = (dep == MDLL_DEP_C3C4) && deep;           // RL2 RL3
      s_d.enh = s_q.pm_cfg[PM_ENH_EN_BIT];                     // RL4
      // snoop request only meaningful in enhanced mode
      s_d.snp_vld = snoop_detect && s_q.pm_cfg[PM_ENH_EN_BIT];
      s_d.snp_cst = s_q.pm_cfg[PM_SNOOP_BIT] ? CST_C0 : CST_C2; // RL5
      // depth limit; legacy mode ignores the field entirely
      s_d.c3_ok = 1'b1;
      s_d.c4_ok = 1'b1;
      if (s_q.pm_cfg[PM_ENH_EN_BIT]) begin                     // RL10
         case (mode)
            PM_MODE_ALL: begin                                 // RL7
               s_d.c3_ok = 1'b1;
               s_d.c4_ok = 1'b1;
            end
            PM_MODE_MAX_C2: begin                              // RL8
               s_d.c3_ok = 1'b0;
               s_d.c4_ok = 1'b0;
            end
            PM_MODE_MAX_C3: begin                              // RL9
               s_d.c3_ok = 1'b1;
               s_d.c4_ok = 1'b0;
            end
            default: begin
               s_d.c3_ok = 1'b1;
               s_d.c4_ok = 1'b1;
            end
         endcase
      end
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata        = s_q.rdata;
   assign mdll_pd_allow    = s_q.pd_allow;
   assign enh_pm_mode      = s_q.enh;
   assign snoop_req_valid  = s_q.snp_vld;
   assign snoop_req_cstate = s_q.snp_cst;
   assign c3_entry_allow   = s_q.c3_ok;
   assign c4_entry_allow   = s_q.c4_ok;

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence wr_dep(logic [2:0] v);
      reg_wr && reg_addr == MDLL_PDC_OFFSET
         && reg_wdata[MDLL_DEP_MSB:MDLL_DEP_LSB] == v;
   endsequence

   // write of the enable bit, then two edges until the output follows
   sequence wr_cfg_enh(logic v);
      reg_wr && reg_addr == PM_CFG_OFFSET
         && reg_wdata[PM_ENH_EN_BIT] == v;
   endsequence

   sequence rd_at(logic [11:0] a);
      reg_rd && reg_addr == a;
   endsequence

   a_dll_never_off: assert property (dep == MDLL_DEP_NEVER
      |=> !mdll_pd_allow) else $error("dll off with code 000"); // RL2
   a_dll_deep_only: assert property (mdll_pd_allow
      |-> $past(deep) && $past(dep) == MDLL_DEP_C3C4)
      else $error("dll off outside c3/c4"); // RL3
   a_dll_dep_store: assert property (wr_dep(MDLL_DEP_C3C4) ##1 deep
      |=> mdll_pd_allow) else $error("dll dependency not applied"); // RL1
   a_mode_bit: assert property (##1 enh_pm_mode
      == $past(s_q.pm_cfg[PM_ENH_EN_BIT]))
      else $error("mode output wrong"); // RL4
   a_snoop_target: assert property (snoop_detect
      && s_q.pm_cfg[PM_ENH_EN_BIT] |=> snoop_req_valid && snoop_req_cstate
      == ($past(s_q.pm_cfg[PM_SNOOP_BIT]) ? CST_C0 : CST_C2))
      else $error("snoop request wrong"); // RL5
   a_max_c2: assert property (s_q.pm_cfg[PM_ENH_EN_BIT]
      && mode == PM_MODE_MAX_C2 |=> !c3_entry_allow && !c4_entry_allow)
      else $error("c3 allowed at max c2"); // RL8
   a_max_c3: assert property (s_q.pm_cfg[PM_ENH_EN_BIT]
      && mode == PM_MODE_MAX_C3 |=> c3_entry_allow && !c4_entry_allow)
      else $error("c4 allowed at max c3"); // RL9
   a_all_allowed: assert property ((!s_q.pm_cfg[PM_ENH_EN_BIT]
      || mode == PM_MODE_ALL) |=> c3_entry_allow && c4_entry_allow)
      else $error("transition blocked"); // RL7 RL10
   a_enh_store: assert property (wr_cfg_enh(1'b1) |=> ##1 enh_pm_mode)
      else $error("enhanced mode not applied"); // RL4
   a_legacy_store: assert property (wr_cfg_enh(1'b0) |=> ##1 !enh_pm_mode)
      else $error("legacy mode not applied"); // RL4
   a_snoop_quiet: assert property (!s_q.pm_cfg[PM_ENH_EN_BIT]
      |=> !snoop_req_valid) else $error("snoop request in legacy"); // RL4
   a_snoop_follow: assert property (!snoop_detect |=> !snoop_req_valid)
      else $error("snoop request without snoop"); // RL5
   a_snoop_c2: assert property (!s_q.pm_cfg[PM_SNOOP_BIT]
      |=> snoop_req_cstate == CST_C2) else $error("snoop not c2"); // RL5
   a_shallow_on: assert property (!deep |=> !mdll_pd_allow)
      else $error("dll off in shallow state"); // RL3
   a_dep_reserved: assert property (dep != MDLL_DEP_C3C4
      |=> !mdll_pd_allow) else $error("dll off on reserved code"); // RL3
   a_dll_on: assert property (dep == MDLL_DEP_C3C4 && deep
      |=> mdll_pd_allow) else $error("dll condition not raised"); // RL1
   // read data stands one cycle only, so a stale word cannot be re-read
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h00000000)
      else $error("read data without read"); // RL12
   a_rd_dll_hi: assert property (rd_at(MDLL_PDC_OFFSET)
      |=> reg_rdata[31:15] == 17'h00000 && reg_rdata[12:7] == 6'h00)
      else $error("dll read-only bits not zero"); // RL12
   a_rd_cfg: assert property (rd_at(PM_CFG_OFFSET)
      |=> reg_rdata == $past(s_q.pm_cfg))
      else $error("config read wrong"); // RL12
   a_rd_unmapped: assert property (reg_rd && reg_addr != MDLL_PDC_OFFSET
      && reg_addr != PM_CFG_OFFSET |=> reg_rdata == 32'h00000000)
      else $error("unmapped read not zero"); // RL12
   a_ro_zero: assert property (s_q.mdll_pdc[15] == 1'b0
      && s_q.mdll_pdc[12:7] == 6'h00 && s_q.pm_cfg[29:5] == 25'h0)
      else $error("read-only bit set"); // RL12

endmodule : cspp_regs

// ===== rtl/cspp_pkg.sv
// ****************************************************************
// offsets, field positions and encodings
// ****************************************************************
package cspp_pkg;
   localparam logic [11:0] MDLL_PDC_OFFSET    = 12'hF0C;
   localparam logic [11:0] PM_CFG_OFFSET      = 12'hF10;
   localparam int          MDLL_DEP_LSB       = 4;
   localparam int          MDLL_DEP_MSB       = 6;
   localparam int          MDLL_RSVD_RW_LSB   = 13;
   localparam int          MDLL_RSVD_RW_MSB   = 14;
   localparam int          PM_ENH_EN_BIT      = 4;
   localparam int          PM_SNOOP_BIT       = 3;
   localparam int          PM_RSVD2_BIT       = 2;
   localparam int          PM_MODE_LSB        = 0;
   localparam int          PM_MODE_MSB        = 1;
   localparam int          PM_RSVD_HI_LSB     = 30;
   localparam int          PM_RSVD_HI_MSB     = 31;
   localparam logic [2:0]  MDLL_DEP_NEVER     = 3'h0;
   localparam logic [2:0]  MDLL_DEP_C3C4      = 3'h6;
   localparam logic [1:0]  PM_MODE_ALL        = 2'h0;
   localparam logic [1:0]  PM_MODE_MAX_C2     = 2'h1;
   localparam logic [1:0]  PM_MODE_MAX_C3     = 2'h2;
   localparam logic [15:0] MDLL_PDC_RESET     = 16'h0000;
   localparam logic [31:0] PM_CFG_RESET       = 32'h00000000;
   // cpu c-state encoding on the cpu_cstate input
   localparam logic [2:0]  CST_C0             = 3'h0;
   localparam logic [2:0]  CST_C1             = 3'h1;
   localparam logic [2:0]  CST_C2             = 3'h2;
   localparam logic [2:0]  CST_C3             = 3'h3;
   localparam logic [2:0]  CST_C4             = 3'h4;
endpackage : cspp_pkg

// ===== tb/cspp_cpu_hub_model.sv
`timescale 1ns/10ps
// ****************************************************************
// cpu c-state tracker and i/o hub stand-in
// ****************************************************************
module cspp_cpu_hub_model
   import cspp_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic [2:0] cstate_tgt,
   input  wire logic       snoop_tgt,
   input  wire logic       snoop_req_valid,
   input  wire logic [2:0] snoop_req_cstate,
   output logic      [2:0] cpu_cstate,
   output logic            snoop_detect,
   output logic      [2:0] hub_req_q
);
   initial cpu_cstate = CST_C0;
   initial snoop_detect = 1'b0;
   initial hub_req_q = 3'h7; // not a c-state: shows no request yet
   // cpu walks one c-state per cycle, so it is slow to settle
   always @(negedge mclk) begin
      if (cpu_cstate < cstate_tgt) cpu_cstate <= cpu_cstate + 3'h1;
      else if (cpu_cstate > cstate_tgt) cpu_cstate <= cpu_cstate - 3'h1;
      snoop_detect <= snoop_tgt;
   end
   // hub latches the c-state asked for by a snoop
   always @(posedge mclk) if (snoop_req_valid) hub_req_q <= snoop_req_cstate;
endmodule : cspp_cpu_hub_model

// ===== tb/test_cstate_power_policy_regs.sv
`timescale 1ns/10ps
`define CHK(g,e) begin compares++; if ((g)!==(e)) begin miscompares++; \
 $display("CHECK FAILED at %0t: got %h want %h",$time,g,e); end end
module test_cstate_power_policy_regs
   import cspp_pkg::*;
;
   typedef struct packed {logic [15:0] dll; logic [31:0] cfg;
      logic [2:0] cst; logic snp; logic [7:0] o;} cspp_row_type;
   logic mclk, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, snoop_detect;
   logic tgt_snp = 1'b0, mdll_pd_allow, enh_pm_mode, snoop_req_valid;
   logic c3_entry_allow, c4_entry_allow;
   logic [11:0] reg_addr = 12'h000;
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   logic [2:0] tgt = 3'h0, cpu_cstate, snoop_req_cstate, hub_req;
   int miscompares = 0, compares = 0, cycles = 0;
   // outputs o: pd, enh, snoop valid, snoop c-state(3), c3 ok, c4 ok
   cspp_row_type rows [7] = '{
      '{16'h0060, 32'h00, CST_C3, 1'b1, 8'b1_0_0_010_1_1},
      '{16'h0060, 32'h11, CST_C4, 1'b1, 8'b1_1_1_010_0_0},
      '{16'h0060, 32'h1A, CST_C2, 1'b1, 8'b0_1_1_000_1_0},
      '{16'h0000, 32'h13, CST_C4, 1'b0, 8'b0_1_0_010_1_1},
      '{16'h0070, 32'h10, CST_C3, 1'b1, 8'b0_1_1_010_1_1},
      '{16'h0060, 32'h01, CST_C0, 1'b0, 8'b0_0_0_010_1_1},
      '{16'h0060, 32'h08, CST_C1, 1'b1, 8'b0_0_0_000_1_1}};
   cspp_regs i_dut (.mclk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
      .cpu_cstate, .snoop_detect, .reg_rdata, .mdll_pd_allow, .enh_pm_mode,
      .snoop_req_valid, .snoop_req_cstate, .c3_entry_allow, .c4_entry_allow);
   cspp_cpu_hub_model i_hub (.mclk, .cstate_tgt(tgt), .snoop_tgt(tgt_snp),
      .snoop_req_valid, .snoop_req_cstate, .cpu_cstate, .snoop_detect,
      .hub_req_q(hub_req));
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // ****************************************************************
   // bus tasks, entered and left at a falling edge
   // ****************************************************************
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
      @(negedge mclk);
      reg_wr = 1'b0;
      // idle cycle: the next strobe never rises in the step it fell
      @(negedge mclk);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      reg_rd = 1'b1; reg_addr = a;
      @(negedge mclk);
      reg_rd = 1'b0;
      `CHK(reg_rdata, e)
      @(negedge mclk);
   endtask : rd
   task automatic conclude();
      $display("miscompares %0d compares %0d", miscompares, compares);
      if (miscompares == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : conclude
   // hang guard: the whole run needs well under 400 cycles
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 1000) begin
         miscompares++;
         conclude();
      end
   end
   // ****************************************************************
   // table rows, then reset and reserved-bit cases
   // ****************************************************************
   initial begin
      repeat (6) @(negedge mclk);
      rst = 1'b0;
      foreach (rows[i]) begin
         wr(MDLL_PDC_OFFSET, {16'h0, rows[i].dll});
         wr(PM_CFG_OFFSET, rows[i].cfg);
         tgt = rows[i].cst;
         tgt_snp = rows[i].snp;
         // slack for the model's one-step-per-cycle c-state walk
         repeat (8) @(negedge mclk);
         `CHK({mdll_pd_allow, enh_pm_mode, snoop_req_valid, snoop_req_cstate,
            c3_entry_allow, c4_entry_allow}, rows[i].o)
         if (rows[i].o[5]) `CHK(hub_req, rows[i].o[4:2])
         rd(PM_CFG_OFFSET, rows[i].cfg);
      end
      rst = 1'b1;
      @(negedge mclk);
      `CHK({mdll_pd_allow, enh_pm_mode, c3_entry_allow, reg_rdata}, 35'h0)
      rst = 1'b0;
      repeat (2) @(negedge mclk);
      `CHK({mdll_pd_allow, c3_entry_allow, c4_entry_allow}, 3'b011)
      rd(MDLL_PDC_OFFSET, 32'h0);
      rd(PM_CFG_OFFSET, 32'h0);
      wr(MDLL_PDC_OFFSET, 32'hFFFFFFFF);
      rd(MDLL_PDC_OFFSET, 32'h0000607F);
      wr(PM_CFG_OFFSET, 32'hFFFFFFFF);
      rd(PM_CFG_OFFSET, 32'hC000001F);
      wr(12'hF14, 32'h0);
      rd(12'hF14, 32'h0);
      rd(PM_CFG_OFFSET, 32'hC000001F);
      wr(PM_CFG_OFFSET, 32'h0); // recommended defaults
      conclude();
   end
endmodule : test_cstate_power_policy_regs
